/* rtl/omsr_pkg.sv */
package omsr_pkg;
// Contract
// [R01] sleep after 1500 idle frames unless forced
// [R02] status: part code, zeros, awake bit
// [R03] horizontal motion accumulates, clears on read
// [R04] motion is eight-bit two's complement
// [R05] vertical motion same, resets to zero
// [R06] surface quality is feature count over two
// [R07] brightest pixel six bits, upper zero
// [R08] darkest pixel six bits, resets to 3f
// [R09] pixel total is frame sum over 128
// [R10] readout byte: frame start, valid, brightness
// [R11] readout write restarts at pixel one
// [R12] after 324 valid reads wrap to one
// [R13] access arms grab, one pixel held
// [R14] host forces awake, collects 324 valid reads
// [R15] 18 by 18 array, column-major numbering
// [R16] 16-bit shutter split high then low
// [R17] host reads shutter high then low
// [R18] exposure loop steps shutter by sixteenth
// [R19] shutter capped at clock/1500 minus 3476
// [R20] inverted code is complement of part code
// [R21] config top bit resets, self-clears
// [R22] config bit six powers analog down
// [R23] unmapped: writes ignored, reads zero
// [R24] motion saturates instead of wrapping
// [R25] writes to read-only registers ignored
  localparam logic [6:0] ADDR_CONFIG = 7'h00;
  localparam logic [6:0] ADDR_STATUS = 7'h01;
  localparam logic [6:0] ADDR_VMOTION = 7'h02;
  localparam logic [6:0] ADDR_HMOTION = 7'h03;
  localparam logic [6:0] ADDR_QUALITY = 7'h04;
  localparam logic [6:0] ADDR_BRIGHT = 7'h05;
  localparam logic [6:0] ADDR_DARK = 7'h06;
  localparam logic [6:0] ADDR_TOTAL = 7'h07;
  localparam logic [6:0] ADDR_PIXEL = 7'h08;
  localparam logic [6:0] ADDR_EXP_HIGH = 7'h09;
  localparam logic [6:0] ADDR_EXP_LOW = 7'h0a;
  localparam logic [6:0] ADDR_INV_CODE = 7'h11;
  localparam int CFG_RESET_BIT = 7;
  localparam int CFG_PD_BIT = 6;
  localparam int CFG_AWAKE_BIT = 0;
  localparam int SER_RW_BIT = 7;
  localparam logic [2:0] SER_LAST = 3'h7;
  localparam logic signed [9:0] MOTION_MAX = 10'sh07f;
  localparam logic signed [9:0] MOTION_MIN = 10'sh380;
  localparam logic [5:0] BRIGHT_RESET = 6'h00;
  localparam logic [5:0] DARK_RESET = 6'h3f;
  localparam logic [15:0] SHUTTER_RESET = 16'h0100;
  localparam logic [15:0] STEP_MIN = 16'h0001;
  localparam logic [5:0] AEC_HI = 6'h39;
  localparam logic [5:0] AEC_LO = 6'h34;
  localparam int AEC_SHIFT = 4;
  localparam int PIX_SIDE = 18;
  localparam logic [8:0] PIX_FIRST = 9'h001;
  localparam logic [8:0] PIX_LAST = 9'(PIX_SIDE * PIX_SIDE);
  localparam int SLEEP_TIME_S = 1;
  localparam int FRAME_RATE_FPS = 1500;
  localparam int SLEEP_FRAMES = SLEEP_TIME_S * FRAME_RATE_FPS;
  localparam int SENSOR_CLK_HZ = 24000000;
  localparam int SHUTTER_DIV = 1500;
  localparam int SHUTTER_OFFSET = 3476;
  localparam int SQ_LSB = 1;
  localparam int SUM_LSB = 7;
  typedef enum logic [2:0] {
    SER_ADDR, SER_WDATA, SER_TURN, SER_RDATA, SER_RELEASE
  } omsr_ser_state_t;
endpackage

/* rtl/omsr_motion.sv */
`timescale 1ns/1ps
module omsr_motion import omsr_pkg::*; (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic clear_in,
  input wire logic delta_valid_in,
  input wire logic [7:0] delta_in,
  output logic [7:0] count_out
);
  logic signed [7:0] count;
  logic signed [9:0] base;
  logic signed [9:0] add;
  logic signed [9:0] next_sum;
  logic signed [7:0] next_count;
  always_comb begin
    base = clear_in ? 10'sh000 : {{2{count[7]}}, count};
    add = delta_valid_in ? {{2{delta_in[7]}}, delta_in} : 10'sh000;
    next_sum = base + add;
    if (next_sum > MOTION_MAX) begin
      next_count = MOTION_MAX[7:0]; // [R24]
    end else if (next_sum < MOTION_MIN) begin
      next_count = MOTION_MIN[7:0]; // [R24]
    end else begin
      next_count = next_sum[7:0]; // [R04]
    end
  end
  // a motion report landing on the read cycle is kept, not lost
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      count <= 8'sh00;
    end else begin
      count <= next_count;
    end
  end
  assign count_out = count;
  AST_SAT_HI: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!clear_in && delta_valid_in && count == 8'sh7f && !delta_in[7])
    |=> count == 8'sh7f) else $error("motion wrapped above max"); // [R24]
  AST_SAT_LO: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    (!clear_in && delta_valid_in && count == 8'sh80 && delta_in[7])
    |=> count == 8'sh80) else $error("motion wrapped below min"); // [R24]
endmodule

/* rtl/omsr_serial.sv */
`timescale 1ns/1ps
module omsr_serial import omsr_pkg::*; (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic sck_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n_out,
  input wire logic [7:0] rdata_in,
  output logic rd_strobe_out,
  output logic wr_strobe_out,
  output logic [6:0] addr_out,
  output logic [7:0] wdata_out
);
  logic sck_meta, sck_sync, sck_prev, sdio_meta, sdio_sync;
  logic sck_rise, sck_fall, drive;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in, shift_out;
  omsr_ser_state_t state;
  // pins are async to the core clock
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sck_meta <= 1'b1;
      sck_sync <= 1'b1;
      sck_prev <= 1'b1;
      sdio_meta <= 1'b0;
      sdio_sync <= 1'b0;
    end else begin
      sck_meta <= sck_in;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      sdio_meta <= sdio_in;
      sdio_sync <= sdio_meta;
    end
  end
  assign sck_rise = sck_sync && !sck_prev;
  assign sck_fall = !sck_sync && sck_prev;
  assign sdio_out = shift_out[7];
  assign sdio_oe_n_out = !drive;
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state <= SER_ADDR;
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      drive <= 1'b0;
      rd_strobe_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      addr_out <= 7'h00;
      wdata_out <= 8'h00;
    end else begin
      rd_strobe_out <= 1'b0;
      wr_strobe_out <= 1'b0;
      if (rd_strobe_out) begin
        shift_out <= rdata_in;
      end
      case (state)
        SER_ADDR, SER_WDATA: begin
          if (sck_rise) begin
            shift_in <= {shift_in[6:0], sdio_sync};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == SER_LAST && state == SER_WDATA) begin
              wdata_out <= {shift_in[6:0], sdio_sync};
              wr_strobe_out <= 1'b1;
              state <= SER_ADDR;
            end else if (bit_cnt == SER_LAST) begin
              addr_out <= {shift_in[5:0], sdio_sync};
              if (shift_in[SER_RW_BIT - 1]) begin
                state <= SER_WDATA;
              end else begin
                rd_strobe_out <= 1'b1;
                state <= SER_TURN;
              end
            end
          end
        end
        SER_TURN: begin
          if (sck_fall) begin
            drive <= 1'b1;
            state <= SER_RDATA;
          end
        end
        SER_RDATA: begin
          if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == SER_LAST) begin
              state <= SER_RELEASE;
            end
          end else if (sck_fall) begin
            shift_out <= {shift_out[6:0], 1'b0};
          end
        end
        default: begin
          if (sck_fall) begin
            drive <= 1'b0;
            state <= SER_ADDR;
          end
        end
      endcase
    end
  end
endmodule

/* rtl/omsr_top.sv */
`timescale 1ns/1ps
module omsr_top import omsr_pkg::*; #(
  parameter int SLEEP_LIMIT = SLEEP_FRAMES,
  parameter int CLK_HZ = SENSOR_CLK_HZ,
  parameter logic [2:0] PART_CODE = 3'h5
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic sck_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n_out,
  input wire logic frame_done_in,
  input wire logic motion_valid_in,
  input wire logic [7:0] dx_in,
  input wire logic [7:0] dy_in,
  input wire logic [8:0] feature_count_in,
  input wire logic [5:0] max_pix_in,
  input wire logic [5:0] min_pix_in,
  input wire logic [14:0] pixel_sum_in,
  input wire logic [5:0] pixel_value_in,
  output logic [8:0] pixel_sel_out,
  output logic awake_out,
  output logic analog_pd_out,
  output logic [15:0] shutter_out
);
  // part code value is arbitrary
  localparam int SLEEP_W = $clog2(SLEEP_LIMIT + 1);
  localparam logic [SLEEP_W-1:0] SLEEP_END = SLEEP_W'(SLEEP_LIMIT - 1);
  localparam logic [15:0] SHUTTER_MAX =
    16'(CLK_HZ / SHUTTER_DIV - SHUTTER_OFFSET);

  function automatic logic is_addr(input logic [6:0] a,
                                   input logic [6:0] t);
    is_addr = (a == t);
  endfunction

  logic rd_strobe, wr_strobe;
  logic [6:0] acc_addr;
  logic [7:0] wdata, rdata;
  logic soft_rst, blk_rstn;
  logic cfg_powerdown, cfg_forced;
  logic awake;
  logic [SLEEP_W-1:0] idle_frames;
  logic motion_seen;
  logic [7:0] vertical_motion, horizontal_motion;
  logic [7:0] surface_quality, pixel_total;
  logic [5:0] brightest_pixel, darkest_pixel;
  logic [8:0] pix_index;
  logic pix_valid, pix_armed;
  logic [5:0] pixel_brightness;
  logic [15:0] shutter, step, next_shutter;
  logic [16:0] raised;
  logic [7:0] exposure_low_hold;
  logic wr_cfg, rd_pix, wr_pix, rd_exp_high;
  logic pix_sof, grab;

  omsr_serial u_serial (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .sck_in(sck_in),
    .sdio_in(sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe_n_out(sdio_oe_n_out),
    .rdata_in(rdata),
    .rd_strobe_out(rd_strobe),
    .wr_strobe_out(wr_strobe),
    .addr_out(acc_addr),
    .wdata_out(wdata)
  );

  // only config and pixel readout accept writes
  assign wr_cfg = wr_strobe && is_addr(acc_addr, ADDR_CONFIG); // [R25]
  assign wr_pix = wr_strobe && is_addr(acc_addr, ADDR_PIXEL); // [R25]
  assign rd_pix = rd_strobe && is_addr(acc_addr, ADDR_PIXEL);
  assign rd_exp_high = rd_strobe && is_addr(acc_addr, ADDR_EXP_HIGH);
  assign blk_rstn = rstn_in && !soft_rst;

  // config survives its own soft reset so the bits written with it stick
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      soft_rst <= 1'b0;
      cfg_powerdown <= 1'b0;
      cfg_forced <= 1'b0;
    end else begin
      soft_rst <= wr_cfg && wdata[CFG_RESET_BIT]; // [R21]
      if (wr_cfg) begin
        cfg_powerdown <= wdata[CFG_PD_BIT]; // [R22]
        cfg_forced <= wdata[CFG_AWAKE_BIT]; // [R01]
      end
    end
  end
  assign analog_pd_out = cfg_powerdown; // [R22]

  // sleep counts frames, not time; a slower frame rate stretches it
  assign motion_seen = motion_valid_in && (dx_in != 8'h00 || dy_in != 8'h00);
  always_ff @(posedge core_clk_in) begin
    if (!blk_rstn) begin
      awake <= 1'b1;
      idle_frames <= '0;
    end else if (cfg_forced || motion_seen) begin
      awake <= 1'b1; // [R01]
      idle_frames <= '0;
    end else if (frame_done_in && awake) begin
      idle_frames <= idle_frames + SLEEP_W'(1);
      if (idle_frames == SLEEP_END) begin
        awake <= 1'b0; // [R01]
      end
    end
  end
  assign awake_out = awake;

  omsr_motion u_vmotion (
    .core_clk_in(core_clk_in),
    .rstn_in(blk_rstn),
    .clear_in(rd_strobe && is_addr(acc_addr, ADDR_VMOTION)), // [R05]
    .delta_valid_in(motion_valid_in),
    .delta_in(dy_in),
    .count_out(vertical_motion)
  );
  omsr_motion u_hmotion (
    .core_clk_in(core_clk_in),
    .rstn_in(blk_rstn),
    .clear_in(rd_strobe && is_addr(acc_addr, ADDR_HMOTION)), // [R03]
    .delta_valid_in(motion_valid_in),
    .delta_in(dx_in),
    .count_out(horizontal_motion)
  );

  // frame statistics follow the imaging side, one update per frame
  always_ff @(posedge core_clk_in) begin
    if (!blk_rstn) begin
      surface_quality <= 8'h00;
      brightest_pixel <= BRIGHT_RESET;
      darkest_pixel <= DARK_RESET; // [R08]
      pixel_total <= 8'h00;
    end else if (frame_done_in) begin
      surface_quality <= feature_count_in[8:SQ_LSB]; // [R06]
      brightest_pixel <= max_pix_in; // [R07]
      darkest_pixel <= min_pix_in; // [R08]
      pixel_total <= pixel_sum_in[14:SUM_LSB]; // [R09]
    end
  end

  // grabber: index walks column-major, 1..324, imaging picks it up
  assign grab = frame_done_in && pix_armed && !pix_valid && !wr_pix;
  always_ff @(posedge core_clk_in) begin
    if (!blk_rstn) begin
      pix_index <= PIX_FIRST;
      pix_valid <= 1'b0;
      pix_armed <= 1'b0;
      pixel_brightness <= 6'h00;
    end else begin
      if (wr_pix) begin
        pix_index <= PIX_FIRST; // [R11]
        pix_valid <= 1'b0;
        pix_armed <= 1'b1; // [R13]
      end else if (rd_pix) begin
        pix_armed <= 1'b1; // [R13]
        if (pix_valid) begin
          pix_valid <= 1'b0;
          if (pix_index == PIX_LAST) begin
            pix_index <= PIX_FIRST; // [R12]
          end else begin
            pix_index <= pix_index + 9'h001; // [R11] [R15]
          end
        end
      end
      // held however stale until read
      if (grab) begin
        pixel_brightness <= pixel_value_in; // [R13]
        pix_valid <= 1'b1;
        pix_armed <= 1'b0;
      end
    end
  end
  assign pixel_sel_out = pix_index; // [R15]
  assign pix_sof = pix_valid && (pix_index == PIX_FIRST); // [R10]

  // exposure loop: one sixteenth per step, never below one count
  always_comb begin
    step = shutter >> AEC_SHIFT; // [R18]
    if (step == 16'h0000) begin
      step = STEP_MIN;
    end
    raised = {1'b0, shutter} + {1'b0, step};
    next_shutter = shutter;
    if (max_pix_in > AEC_HI) begin
      next_shutter = (shutter > step) ? shutter - step : STEP_MIN; // [R18]
    end else if (max_pix_in < AEC_LO) begin
      if (raised > {1'b0, SHUTTER_MAX}) begin
        next_shutter = SHUTTER_MAX; // [R19]
      end else begin
        next_shutter = raised[15:0]; // [R18]
      end
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!blk_rstn) begin
      shutter <= SHUTTER_RESET; // [R16]
    end else if (frame_done_in) begin
      shutter <= next_shutter;
    end
  end
  assign shutter_out = shutter;

  // low byte snapped with the high read so the pair is coherent
  always_ff @(posedge core_clk_in) begin
    if (!blk_rstn) begin
      exposure_low_hold <= SHUTTER_RESET[7:0];
    end else if (rd_exp_high) begin
      exposure_low_hold <= shutter[7:0]; // [R16] [R17]
    end
  end

  always_comb begin
    if (is_addr(acc_addr, ADDR_CONFIG)) begin
      rdata = {soft_rst, cfg_powerdown, 5'h00, cfg_forced};
    end else if (is_addr(acc_addr, ADDR_STATUS)) begin
      rdata = {PART_CODE, 4'h0, awake}; // [R02]
    end else if (is_addr(acc_addr, ADDR_VMOTION)) begin
      rdata = vertical_motion; // [R04]
    end else if (is_addr(acc_addr, ADDR_HMOTION)) begin
      rdata = horizontal_motion; // [R04]
    end else if (is_addr(acc_addr, ADDR_QUALITY)) begin
      rdata = surface_quality;
    end else if (is_addr(acc_addr, ADDR_BRIGHT)) begin
      rdata = {2'h0, brightest_pixel}; // [R07]
    end else if (is_addr(acc_addr, ADDR_DARK)) begin
      rdata = {2'h0, darkest_pixel}; // [R08]
    end else if (is_addr(acc_addr, ADDR_TOTAL)) begin
      rdata = pixel_total;
    end else if (is_addr(acc_addr, ADDR_PIXEL)) begin
      rdata = {pix_sof, pix_valid, pixel_brightness}; // [R10]
    end else if (is_addr(acc_addr, ADDR_EXP_HIGH)) begin
      rdata = shutter[15:8]; // [R16]
    end else if (is_addr(acc_addr, ADDR_EXP_LOW)) begin
      rdata = exposure_low_hold; // [R16]
    end else if (is_addr(acc_addr, ADDR_INV_CODE)) begin
      rdata = {4'h0, ~{1'b0, PART_CODE}}; // [R20]
    end else begin
      rdata = 8'h00; // [R23]
    end
  end

  AST_FORCED_AWAKE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) cfg_forced && !soft_rst |=> awake)
    else $error("asleep while forced awake"); // [R01]
  AST_SLEEP_CAUSE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) $fell(awake) |->
    $past(frame_done_in) && !$past(cfg_forced) &&
    $past(idle_frames) == SLEEP_END)
    else $error("fell asleep without idle limit"); // [R01]
  AST_HMOTION_CLEAR: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    rd_strobe && is_addr(acc_addr, ADDR_HMOTION) && !motion_valid_in
    |=> horizontal_motion == 8'h00)
    else $error("horizontal motion not cleared"); // [R03]
  AST_VMOTION_CLEAR: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    rd_strobe && is_addr(acc_addr, ADDR_VMOTION) && !motion_valid_in
    |=> vertical_motion == 8'h00)
    else $error("vertical motion not cleared"); // [R05]
  AST_PIX_RESTART: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) wr_pix && !soft_rst
    |=> pix_index == PIX_FIRST && !pix_valid && pix_armed)
    else $error("pixel write did not restart"); // [R11]
  AST_PIX_WRAP: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    rd_pix && pix_valid && pix_index == PIX_LAST && !soft_rst
    |=> pix_index == PIX_FIRST)
    else $error("pixel index did not wrap"); // [R12]
  AST_PIX_HOLD: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    pix_valid && !rd_pix && !wr_pix && !soft_rst
    |=> pix_valid && $stable(pixel_brightness) && $stable(pix_index))
    else $error("held pixel lost"); // [R13]
  AST_SHUTTER_CAP: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) shutter <= SHUTTER_MAX || shutter == SHUTTER_RESET)
    else $error("shutter above max"); // [R19]
  AST_SHUTTER_DOWN: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    frame_done_in && !soft_rst && max_pix_in > AEC_HI && shutter > 16'h00ff
    |=> shutter == $past(shutter) - ($past(shutter) >> AEC_SHIFT))
    else $error("shutter step not a sixteenth"); // [R18]
  AST_SOFT_RESET: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in) wr_cfg && wdata[CFG_RESET_BIT]
    |=> soft_rst ##1 !soft_rst && darkest_pixel == DARK_RESET)
    else $error("soft reset bit misbehaved"); // [R21] [R08]
  AST_RO_WRITE: assert property (@(posedge core_clk_in)
    disable iff (!rstn_in)
    wr_strobe && is_addr(acc_addr, ADDR_EXP_HIGH) && !frame_done_in
    && !soft_rst |=> $stable(shutter))
    else $error("write altered shutter"); // [R25]
endmodule

/* dv/omsr_host.sv */
`timescale 1ns/1ps
module omsr_host (
  output logic sck_out,
  output logic sdio_out,
  output logic sdio_oe_n_out,
  input wire logic sdio_in
);
  // clock idles high, stops between frames; bits change on falls
  initial begin
    sck_out = 1'b1;
    sdio_out = 1'b1;
    sdio_oe_n_out = 1'b1;
  end
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      sdio_oe_n_out = 1'b0;
      sdio_out = b[i];
      #80;
      sck_out = 1'b1;
      #80;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    put({1'b1, a});
    put(d);
    sdio_oe_n_out = 1'b1;
    // room for the core to apply the write
    #200;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    put({1'b0, a});
    // release before the fall that hands the pin over
    sdio_oe_n_out = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      #80;
      sck_out = 1'b1;
      d[i] = sdio_in;
      #80;
    end
  endtask
endmodule

/* dv/omsr_top_tb.sv */
`timescale 1ns/1ps
module omsr_top_tb;
  import omsr_pkg::*;
  // arbitrary part code
  localparam logic [2:0] CODE = 3'h5;
  localparam int SLP = 4;
  localparam logic [15:0] SMAX = 16'(CLK_MAX);
  localparam int CLK_MAX = SENSOR_CLK_HZ / SHUTTER_DIV - SHUTTER_OFFSET;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic sck, h_d, h_oe_n, dev_d, dev_oe_n, sdio;
  logic float_v = 1'b0;
  logic frame_done_in = 1'b0;
  logic motion_valid_in = 1'b0;
  logic [7:0] dx_in = 8'h00;
  logic [7:0] dy_in = 8'h00;
  logic [8:0] feature_count_in = 9'h000;
  logic [5:0] max_pix_in = 6'h00;
  logic [5:0] min_pix_in = 6'h00;
  logic [14:0] pixel_sum_in = 15'h0000;
  logic [5:0] pixel_value_in = 6'h00;
  logic [5:0] salt = 6'h00;
  logic [8:0] pixel_sel_out;
  logic awake_out, analog_pd_out;
  logic [15:0] shutter_out;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // undriven pin toggles so a stale level never passes
  assign sdio = !dev_oe_n ? dev_d : (!h_oe_n ? h_d : float_v);
  always @(negedge sck) float_v <= ~float_v;
  always #5 core_clk_in = ~core_clk_in;
  omsr_top #(.SLEEP_LIMIT(SLP), .PART_CODE(CODE)) u_omsr_top (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .sck_in(sck),
    .sdio_in(sdio), .sdio_out(dev_d), .sdio_oe_n_out(dev_oe_n),
    .frame_done_in(frame_done_in), .motion_valid_in(motion_valid_in),
    .dx_in(dx_in), .dy_in(dy_in), .feature_count_in(feature_count_in),
    .max_pix_in(max_pix_in), .min_pix_in(min_pix_in),
    .pixel_sum_in(pixel_sum_in), .pixel_value_in(pixel_value_in),
    .pixel_sel_out(pixel_sel_out), .awake_out(awake_out),
    .analog_pd_out(analog_pd_out), .shutter_out(shutter_out));
  omsr_host u_omsr_host (.sck_out(sck), .sdio_out(h_d),
    .sdio_oe_n_out(h_oe_n), .sdio_in(sdio));
  task automatic close_out();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 130000) begin
      err_count++;
      close_out();
    end
  end
  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    chk_w({8'h00, g}, {8'h00, e});
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_omsr_host.rd(a, d);
    chk_b(d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic frame(input logic [5:0] mx);
    tick(1);
    max_pix_in = mx;
    pixel_value_in = pixel_sel_out[5:0] ^ salt;
    frame_done_in = 1'b1;
    tick(1);
    frame_done_in = 1'b0;
    tick(1);
  endtask
  task automatic mot(input logic [7:0] x, input logic [7:0] y);
    tick(1);
    dx_in = x;
    dy_in = y;
    motion_valid_in = 1'b1;
    tick(1);
    motion_valid_in = 1'b0;
    tick(1);
  endtask
  task automatic t_reset();
    rdc(ADDR_STATUS, {CODE, 4'h0, 1'b1});
    rdc(ADDR_VMOTION, 8'h00);
    rdc(ADDR_HMOTION, 8'h00);
    rdc(ADDR_QUALITY, 8'h00);
    rdc(ADDR_BRIGHT, 8'h00);
    rdc(ADDR_DARK, 8'h3f);
    rdc(ADDR_TOTAL, 8'h00);
    rdc(ADDR_PIXEL, 8'h00);
    rdc(ADDR_EXP_HIGH, 8'h01);
    rdc(ADDR_EXP_LOW, 8'h00);
    rdc(ADDR_INV_CODE, {4'h0, ~{1'b0, CODE}});
    u_omsr_host.wr(7'h0b, 8'h5a);
    rdc(7'h0b, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_motion();
    mot(8'h70, 8'hf0);
    mot(8'h70, 8'hff);
    rdc(ADDR_HMOTION, 8'h7f);
    rdc(ADDR_HMOTION, 8'h00);
    rdc(ADDR_VMOTION, 8'hef);
    mot(8'h00, 8'h80);
    mot(8'h00, 8'hff);
    rdc(ADDR_VMOTION, 8'h80);
    rdc(ADDR_VMOTION, 8'h00);
    $display("motion done");
  endtask
  task automatic t_sleep();
    u_omsr_host.wr(ADDR_CONFIG, 8'h00);
    repeat (SLP - 1) frame(6'h36);
    chk_w({15'h0, awake_out}, 16'h0001);
    repeat (2) frame(6'h36);
    chk_w({15'h0, awake_out}, 16'h0000);
    rdc(ADDR_STATUS, {CODE, 4'h0, 1'b0});
    mot(8'h01, 8'h00);
    chk_w({15'h0, awake_out}, 16'h0001);
    u_omsr_host.wr(ADDR_CONFIG, 8'h01);
    repeat (SLP + 2) frame(6'h36);
    chk_w({15'h0, awake_out}, 16'h0001);
    mot(8'h05, 8'h00);
    u_omsr_host.wr(ADDR_CONFIG, 8'hc1);
    chk_w({15'h0, analog_pd_out}, 16'h0001);
    chk_w(shutter_out, SHUTTER_RESET);
    rdc(ADDR_CONFIG, 8'h41);
    rdc(ADDR_HMOTION, 8'h00);
    u_omsr_host.wr(ADDR_CONFIG, 8'h01);
    chk_w({15'h0, analog_pd_out}, 16'h0000);
    $display("sleep and config done");
  endtask
  task automatic t_stats();
    logic [15:0] s;
    feature_count_in = 9'h1ff;
    min_pix_in = 6'h00;
    pixel_sum_in = 15'h4fff;
    frame(6'h3f);
    chk_w(shutter_out, 16'h00f0);
    rdc(ADDR_QUALITY, 8'hff);
    rdc(ADDR_BRIGHT, 8'h3f);
    rdc(ADDR_DARK, 8'h00);
    rdc(ADDR_TOTAL, 8'h9f);
    u_omsr_host.wr(ADDR_QUALITY, 8'h00);
    u_omsr_host.wr(ADDR_EXP_HIGH, 8'h33);
    rdc(ADDR_QUALITY, 8'hff);
    rdc(ADDR_EXP_HIGH, 8'h00);
    rdc(ADDR_EXP_LOW, 8'hf0);
    // long dark run drives the loop into its ceiling
    s = 16'h00f0;
    for (int i = 0; i < 120; i++) begin
      frame(6'h00);
      s = s + ((s >> 4) == 16'h0 ? 16'h1 : s >> 4);
      if (s > SMAX)
        s = SMAX;
    end
    chk_w(shutter_out, s);
    frame(6'h3f);
    chk_w(shutter_out, s - (s >> 4));
    $display("stats and exposure done");
  endtask
  task automatic t_pixel();
    logic [5:0] e;
    u_omsr_host.wr(ADDR_PIXEL, 8'h00);
    rdc(ADDR_PIXEL, 8'h00);
    for (int n = 1; n <= 325; n++) begin
      chk_w({7'h0, pixel_sel_out}, 16'(n == 325 ? 1 : n));
      salt = 6'(n * 7);
      e = (n == 325 ? 6'h01 : 6'(n)) ^ salt;
      frame(6'h36);
      if (n == 5) begin
        // a later frame must not replace the held pixel
        salt = 6'h2a;
        frame(6'h36);
      end
      rdc(ADDR_PIXEL, {n == 1 || n == 325, 1'b1, e});
    end
    $display("pixel readout done");
  endtask
  initial begin
    repeat (20) @(posedge core_clk_in);
    #1;
    rstn_in = 1'b1;
    tick(4);
    t_reset();
    t_motion();
    t_sleep();
    t_stats();
    t_pixel();
    close_out();
  end
endmodule
